// ==== rtl/serial_peripheral_port.v ====
/*
 Serial peripheral port with master and slave modes, software-sized receive and transmit
 queues, AXI4-Lite register slave and a level interrupt.
 Assumes one 125 MHz clock; all link pins come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`include "serial_port_consts.vh"

module serial_peripheral_port (
   input wire CLK,
   input wire RESET_N,
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire SCLK_IN,
   output reg SCLK_OUT,
   output reg SCLK_OE,
   input wire MOSI_IN,
   output reg MOSI_OUT,
   output reg MOSI_OE,
   input wire MISO_IN,
   output reg MISO_OUT,
   output reg MISO_OE,
   input wire SS_N_IN,
   output reg SS_N_OUT,
   output reg IRQ
);
   // ==========================================================
   // Configuration and state
   reg master, cpha, cpol, lsb;
   reg [4:0] wlen;
   reg [4:0] rate_code;
   reg [7:0] rxq_len, txq_len;
   reg [`IRQ_W-1:0] istat, imask;
   reg [16:0] acc;
   reg tick;
   reg sclk_m, sclk_s, sclk_d, mosi_m, mosi_s, miso_m, miso_s, ss_m, ss_s;
   reg busy, fin, ph;
   reg [4:0] bidx;
   reg [15:0] txw, rxw;
   reg [15:0] rx_mem [0:`QMAX-1];
   reg [15:0] tx_mem [0:`QMAX-1];
   reg [3:0] rx_wp, rx_rp, tx_wp, tx_rp;
   reg [4:0] rx_cnt, tx_cnt;
   reg [7:0] wa, ra;
   reg [31:0] wd;

   // ==========================================================
   // Rate selection and half-bit tick
   reg [16:0] step;
   always @* begin
      case (rate_code)
         `RATE_C2: step = 17'd2 * 17'd`RATE_KHZ2;
         `RATE_C5: step = 17'd2 * 17'd`RATE_KHZ5;
         `RATE_C20: step = 17'd2 * 17'd`RATE_KHZ20;
         default: step = 17'd2 * 17'd`RATE_KHZ1;
      endcase
   end
   // Fractional accumulator keeps the average rate exact where the divider is not whole
   wire [17:0] acc_sum = {1'b0, acc} + {1'b0, step};
   always @(posedge CLK) begin
      if (!RESET_N) begin
         acc <= 17'h00000;
         tick <= 1'b0;
      end else if (acc_sum >= `CLK_KHZ) begin
         acc <= acc_sum[16:0] - 17'd`CLK_KHZ;
         tick <= 1'b1;
      end else begin
         acc <= acc_sum[16:0];
         tick <= 1'b0;
      end
   end

   // ==========================================================
   // Pin synchronisers
   always @(posedge CLK) begin
      if (!RESET_N) begin
         {sclk_m, sclk_s, sclk_d} <= 3'h0;
         {mosi_m, mosi_s, miso_m, miso_s} <= 4'h0;
         {ss_m, ss_s} <= 2'h3;
      end else begin
         sclk_m <= SCLK_IN;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         mosi_m <= MOSI_IN;
         mosi_s <= mosi_m;
         miso_m <= MISO_IN;
         miso_s <= miso_m;
         ss_m <= SS_N_IN;
         ss_s <= ss_m;
      end
   end

   // ==========================================================
   // Queue capacity and status
   function [4:0] qcap;
      input [7:0] len;
      begin
         if (len == 8'h00)
            qcap = 5'h01;
         else if (len < {3'h0, `QMIN})
            qcap = `QMIN;
         else if (len > {3'h0, `QMAX})
            qcap = `QMAX;
         else
            qcap = len[4:0];
      end
   endfunction
   wire [4:0] rx_cap = qcap(rxq_len);
   wire [4:0] tx_cap = qcap(txq_len);
   wire [4:0] tx_space = (tx_cnt >= tx_cap) ? 5'h00 : tx_cap - tx_cnt;
   wire [4:0] rx_stat = (rxq_len == 8'h00) ? {4'h0, rx_cnt != 5'h00} : rx_cnt;
   wire [4:0] tx_stat = (txq_len == 8'h00) ? {4'h0, tx_space != 5'h00} : tx_space;

   // ==========================================================
   // Shift engine edges
   function [3:0] bitpos;
      input [4:0] idx;
      input [4:0] len;
      input lsbf;
      reg [4:0] t;
      begin
         t = len - 5'h01 - idx;
         bitpos = lsbf ? idx[3:0] : t[3:0];
      end
   endfunction
   wire din = master ? miso_s : mosi_s;
   // Master edges come from the rate tick, slave edges only from the far clock
   wire lead_ev = busy & (master ? (tick & ~ph) : (sclk_d == cpol && sclk_s != cpol));
   wire trail_ev = busy & (master ? (tick & ph) : (sclk_d != cpol && sclk_s == cpol));
   wire samp_ev = cpha ? trail_ev : lead_ev;
   wire drv_ev = cpha ? lead_ev : trail_ev;
   wire last = (bidx == wlen - 5'h01);
   wire tx_avail = (tx_cnt != 5'h00);
   wire m_start = master & ~busy & ~fin & tick & tx_avail;
   wire s_start = ~master & ~busy & ~fin & ~ss_s;
   wire start = m_start | s_start;
   wire [15:0] tx_head = tx_mem[tx_rp];
   wire [15:0] load_w = tx_avail ? tx_head : 16'h0000;
   wire rx_push = fin & (rx_cnt < rx_cap);
   wire rx_ovr = fin & ~(rx_cnt < rx_cap);

   // ==========================================================
   // Register slave handshake conditions
   wire w_do_raw = ~S_AXI_AWREADY & ~S_AXI_WREADY & ~S_AXI_BVALID;
   wire w_tx = (wa == `OFS_TXDATA);
   wire w_do = w_do_raw & ~(w_tx & tx_space == 5'h00);
   wire tx_push = w_do & w_tx & S_AXI_WSTRB[0];
   wire r_pend = ~S_AXI_ARREADY & ~S_AXI_RVALID;
   wire r_rx = (ra == `OFS_RXDATA);
   wire r_do = r_pend & ~(r_rx & rx_cnt == 5'h00);
   wire rx_pop = r_do & r_rx;
   wire tx_pop = start & tx_avail;
   wire ist_clr = r_do & (ra == `OFS_ISTAT);
   wire [`IRQ_W-1:0] ev = {rx_ovr, tx_pop, rx_push};
   // Set wins over the read clear
   wire [`IRQ_W-1:0] next_istat = (ist_clr ? {`IRQ_W{1'b0}} : istat) | ev;

   // ==========================================================
   // Shift engine
   always @(posedge CLK) begin
      if (!RESET_N) begin
         busy <= 1'b0;
         fin <= 1'b0;
         ph <= 1'b0;
         bidx <= 5'h00;
         txw <= 16'h0000;
         rxw <= 16'h0000;
         SCLK_OUT <= 1'b0;
         MOSI_OUT <= 1'b0;
         MISO_OUT <= 1'b0;
         SS_N_OUT <= 1'b1;
      end else begin
         fin <= 1'b0;
         if (!master && ss_s) begin
            busy <= 1'b0;
            bidx <= 5'h00;
         end else if (start) begin
            busy <= 1'b1;
            ph <= 1'b0;
            bidx <= 5'h00;
            txw <= load_w;
            rxw <= 16'h0000;
            if (!cpha) begin
               MOSI_OUT <= load_w[bitpos(5'h00, wlen, lsb)];
               MISO_OUT <= load_w[bitpos(5'h00, wlen, lsb)];
            end
         end else if (busy) begin
            if (samp_ev)
               rxw[bitpos(bidx, wlen, lsb)] <= din;
            if (drv_ev && cpha) begin
               MOSI_OUT <= txw[bitpos(bidx, wlen, lsb)];
               MISO_OUT <= txw[bitpos(bidx, wlen, lsb)];
            end
            if (trail_ev) begin
               if (last) begin
                  busy <= 1'b0;
                  fin <= 1'b1;
               end else begin
                  bidx <= bidx + 5'h01;
                  if (!cpha) begin
                     MOSI_OUT <= txw[bitpos(bidx + 5'h01, wlen, lsb)];
                     MISO_OUT <= txw[bitpos(bidx + 5'h01, wlen, lsb)];
                  end
               end
            end
            if (master && tick)
               ph <= ~ph;
         end
         // Clock rests at the polarity level between words
         if (master && busy && tick)
            SCLK_OUT <= ~SCLK_OUT;
         else if (!busy || !master)
            SCLK_OUT <= cpol;
         SS_N_OUT <= ~(master & (busy | start));
      end
   end

   // ==========================================================
   // Queues
   always @(posedge CLK) begin
      if (tx_push)
         tx_mem[tx_wp] <= wd[15:0];
      if (rx_push)
         rx_mem[rx_wp] <= rxw;
   end
   always @(posedge CLK) begin
      if (!RESET_N) begin
         rx_wp <= 4'h0;
         rx_rp <= 4'h0;
         tx_wp <= 4'h0;
         tx_rp <= 4'h0;
         rx_cnt <= 5'h00;
         tx_cnt <= 5'h00;
      end else begin
         if (tx_push)
            tx_wp <= tx_wp + 4'h1;
         if (tx_pop)
            tx_rp <= tx_rp + 4'h1;
         if (rx_push)
            rx_wp <= rx_wp + 4'h1;
         if (rx_pop)
            rx_rp <= rx_rp + 4'h1;
         tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
         rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   // ==========================================================
   // Register slave
   always @(posedge CLK) begin
      if (!RESET_N) begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OK;
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RRESP <= `RESP_OK;
         S_AXI_RDATA <= 32'h00000000;
         wa <= 8'h00;
         ra <= 8'h00;
         wd <= 32'h00000000;
         master <= 1'b0;
         cpha <= 1'b0;
         cpol <= 1'b0;
         lsb <= 1'b0;
         wlen <= `LEN_RESET;
         rate_code <= `RATE_C1;
         rxq_len <= 8'h00;
         txq_len <= 8'h00;
         istat <= {`IRQ_W{1'b0}};
         imask <= {`IRQ_W{1'b0}};
         IRQ <= 1'b0;
         SCLK_OE <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OE <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            S_AXI_AWREADY <= 1'b0;
            wa <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            S_AXI_WREADY <= 1'b0;
            wd <= S_AXI_WDATA;
         end
         // A write to a full transmitter holds its response until room appears
         if (w_do) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= `RESP_OK;
            case (wa)
               `OFS_CTRL: begin
                  if (S_AXI_WSTRB[0]) begin
                     master <= wd[`CTRL_MASTER];
                     cpha <= wd[`CTRL_CPHA];
                     cpol <= wd[`CTRL_CPOL];
                     lsb <= wd[`CTRL_LSB];
                  end
                  if (S_AXI_WSTRB[1] && wd[`CTRL_LEN_HI:`CTRL_LEN_LO] >= `LEN_MIN &&
                      wd[`CTRL_LEN_HI:`CTRL_LEN_LO] <= `LEN_MAX)
                     wlen <= wd[`CTRL_LEN_HI:`CTRL_LEN_LO];
               end
               `OFS_RATE: begin
                  if (S_AXI_WSTRB[0] && (wd[4:0] == `RATE_C1 || wd[4:0] == `RATE_C2 ||
                      wd[4:0] == `RATE_C5 || wd[4:0] == `RATE_C20) && wd[7:5] == 3'h0)
                     rate_code <= wd[4:0];
               end
               `OFS_TXDATA: begin
               end
               `OFS_RXQ: begin
                  if (S_AXI_WSTRB[0])
                     rxq_len <= wd[7:0];
               end
               `OFS_TXQ: begin
                  if (S_AXI_WSTRB[0])
                     txq_len <= wd[7:0];
               end
               `OFS_IMASK: begin
                  if (S_AXI_WSTRB[0])
                     imask <= wd[`IRQ_W-1:0];
               end
               `OFS_RXDATA, `OFS_RXSTAT, `OFS_TXSTAT, `OFS_ISTAT: begin
               end
               default: S_AXI_BRESP <= `RESP_ERR;
            endcase
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            ra <= {S_AXI_ARADDR[7:2], 2'b00};
         end
         if (r_do) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RESP_OK;
            case (ra)
               `OFS_CTRL: S_AXI_RDATA <= {19'h00000, wlen, 4'h0, lsb, cpol, cpha, master};
               `OFS_RATE: S_AXI_RDATA <= {27'h0000000, rate_code};
               `OFS_TXDATA: S_AXI_RDATA <= 32'h00000000;
               `OFS_RXDATA: S_AXI_RDATA <= {16'h0000, rx_mem[rx_rp]};
               `OFS_RXSTAT: S_AXI_RDATA <= {27'h0000000, rx_stat};
               `OFS_TXSTAT: S_AXI_RDATA <= {27'h0000000, tx_stat};
               `OFS_RXQ: S_AXI_RDATA <= {24'h000000, rxq_len};
               `OFS_TXQ: S_AXI_RDATA <= {24'h000000, txq_len};
               `OFS_ISTAT: S_AXI_RDATA <= {{(32-`IRQ_W){1'b0}}, istat};
               `OFS_IMASK: S_AXI_RDATA <= {{(32-`IRQ_W){1'b0}}, imask};
               default: begin
                  S_AXI_RDATA <= 32'h00000000;
                  S_AXI_RRESP <= `RESP_ERR;
               end
            endcase
         end
         if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
         istat <= next_istat;
         IRQ <= |(next_istat & imask);
         SCLK_OE <= master;
         MOSI_OE <= master;
         MISO_OE <= ~master & ~ss_s;
      end
   end
endmodule // serial_peripheral_port

// ==== rtl/serial_port_consts.vh ====
/*
 Register map, field positions, reset values and timing constants of the serial peripheral port.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_RATE 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0c
`define OFS_RXSTAT 8'h10
`define OFS_TXSTAT 8'h14
`define OFS_RXQ 8'h18
`define OFS_TXQ 8'h1c
`define OFS_ISTAT 8'h20
`define OFS_IMASK 8'h24
// ==========================================================
// Control fields and reset values
`define CTRL_MASTER 0
`define CTRL_CPHA 1
`define CTRL_CPOL 2
`define CTRL_LSB 3
`define CTRL_LEN_HI 12
`define CTRL_LEN_LO 8
`define LEN_MIN 5'h02
`define LEN_MAX 5'h10
`define LEN_RESET 5'h08
// ==========================================================
// Rate codes and serial clock rates in kHz
`define RATE_C1 5'h01
`define RATE_C2 5'h02
`define RATE_C5 5'h05
`define RATE_C20 5'h14
`define RATE_KHZ1 1250
`define RATE_KHZ2 2500
`define RATE_KHZ5 5000
`define RATE_KHZ20 20000
`define CLK_KHZ 125000
// ==========================================================
// Queues and interrupts
`define QMAX 5'h10
`define QMIN 5'h05
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_OVR 2
`define IRQ_W 3
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

// ==== bench/spp_checker_props.sv ====
/*
 Checker for the serial peripheral port: bus handshakes and link framing.
 Assumes binding to the top module; it sees only that module's ports.
*/
`timescale 1ns/1ps
module spp_checker (
   input logic CLK,
   input logic RESET_N,
   input logic S_AXI_AWVALID,
   input logic S_AXI_AWREADY,
   input logic S_AXI_BVALID,
   input logic S_AXI_BREADY,
   input logic [1:0] S_AXI_BRESP,
   input logic S_AXI_ARVALID,
   input logic S_AXI_ARREADY,
   input logic S_AXI_RVALID,
   input logic S_AXI_RREADY,
   input logic [1:0] S_AXI_RRESP,
   input logic [31:0] S_AXI_RDATA,
   input logic SCLK_OUT,
   input logic SCLK_OE,
   input logic MOSI_OE,
   input logic MISO_OE,
   input logic SS_N_OUT
);
   // ==========
   // Helper logic
   // Edges are counted one cycle late, so the frame check looks one cycle after the frame ends
   logic idle_lvl, last_clk, ss_d;
   logic [5:0] edges;
   always @(posedge CLK) begin
      last_clk <= SCLK_OUT;
      ss_d <= SS_N_OUT;
      if (SS_N_OUT) idle_lvl <= SCLK_OUT;
      if (!RESET_N || (SS_N_OUT && ss_d)) edges <= 6'h00;
      else if (SCLK_OUT != last_clk) edges <= edges + 6'h01;
   end
   // ==========
   // Properties
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_aw_take; S_AXI_AWVALID && S_AXI_AWREADY; endsequence
   sequence s_b_take; S_AXI_BVALID && S_AXI_BREADY; endsequence
   sequence s_r_take; S_AXI_RVALID && S_AXI_RREADY; endsequence
   sequence s_frame_end; $rose(SS_N_OUT); endsequence
   a_aw_blocked: assert property (s_aw_take |=> !S_AXI_AWREADY && !S_AXI_BVALID) else $error("aw ready after take");
   a_b_release: assert property (s_b_take |=> !S_AXI_BVALID && S_AXI_AWREADY) else $error("write not released");
   a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   a_ar_blocked: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_ARREADY && !S_AXI_RVALID)
      else $error("ar ready after take");
   a_r_release: assert property (s_r_take |=> !S_AXI_RVALID && S_AXI_ARREADY) else $error("read not released");
   a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   a_err_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
      else $error("error read not zero");
   a_mode_pins: assert property (SCLK_OE == MOSI_OE && !(MISO_OE && SCLK_OE)) else $error("mode pins");
   a_frame_master: assert property (!SS_N_OUT |-> SCLK_OE) else $error("frame outside master");
   a_idle_level: assert property (s_frame_end |-> SCLK_OUT == idle_lvl) else $error("clock rest level");
   a_bit_clocks: assert property (s_frame_end |=> edges[0] == 1'h0 && edges >= 6'h04 && edges <= 6'h20)
      else $error("clock count");
endmodule // spp_checker
bind serial_peripheral_port spp_checker spp_checker_inst (.CLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
   .S_AXI_RRESP, .S_AXI_RDATA, .SCLK_OUT, .SCLK_OE, .MOSI_OE, .MISO_OE, .SS_N_OUT);

// ==== bench/far_slave.sv ====
/*
 Far slave model for master-mode words.
 Assumes the bench supplies its phase, polarity, order, length and reply word.
*/
`timescale 1ns/1ps
module far_slave (
   input logic sclk,
   input logic ss_n,
   input logic mosi,
   input logic cpha,
   input logic cpol,
   input logic lsb,
   input logic [4:0] len,
   input logic [15:0] tx_word,
   output logic miso,
   output logic [15:0] rx_word
);
   // ==========
   // Shift logic
   integer d, s;
   initial miso = 1'h0;
   always @(negedge ss_n) begin
      d = 0;
      s = 0;
      rx_word = 16'h0;
      miso = tx_word[lsb ? 0 : len - 1];
   end
   // No pull on the line, so a released line must not keep showing the last bit
   always @(posedge ss_n) miso = ~miso;
   always @(sclk) begin
      if (!ss_n && (sclk != cpol) != cpha) begin
         rx_word[lsb ? s : len - 1 - s] = mosi;
         s = s + 1;
      end else if (!ss_n) begin
         d = d + !cpha;
         if (d < len) miso = tx_word[lsb ? d : len - 1 - d];
         d = d + cpha;
      end
   end
endmodule // far_slave

// ==== bench/tb_top.sv ====
/*
 Testbench: registers, master words against the far slave, one slave word, interrupt and queue status.
 Assumes the design, the checker and the far slave model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   logic CLK = 1'h0, RESET_N = 1'h0, SCLK_IN = 1'h0, MOSI_IN = 1'h0, SS_N_IN = 1'h1;
   logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] S_AXI_WDATA = 32'h0, q, t, u;
   wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SCLK_OUT, SCLK_OE, MOSI_OUT;
   wire MOSI_OE, MISO_IN, MISO_OUT, MISO_OE, SS_N_OUT, IRQ;
   wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA;
   wire [15:0] frx;
   logic cpha = 1'h0, cpol = 1'h0, lsb = 1'h0;
   logic [4:0] len = 5'h08, h;
   logic [15:0] ftx = 16'h0;
   logic [1:0] rsp;
   logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h05, 8'h14};
   integer seed = 42, bad_count = 0, checked = 0, i, j, k;
   initial forever #4 CLK = ~CLK;
   serial_peripheral_port serial_peripheral_port_inst (.CLK, .RESET_N, .S_AXI_AWADDR(addr), .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hf), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR(addr), .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY, .SCLK_IN, .SCLK_OUT, .SCLK_OE, .MOSI_IN, .MOSI_OUT, .MOSI_OE, .MISO_IN, .MISO_OUT, .MISO_OE,
      .SS_N_IN, .SS_N_OUT, .IRQ);
   far_slave far_slave_inst (.sclk(SCLK_OUT), .ss_n(SS_N_OUT), .mosi(MOSI_OUT), .cpha, .cpol, .lsb, .len,
      .tx_word(ftx), .miso(MISO_IN), .rx_word(frx));
   // ==========
   // Tasks
   function automatic logic [31:0] msk(input logic [4:0] n);
      msk = (32'h1 << n) - 32'h1;
   endfunction
   task wrap_up;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Each channel is judged at the rising edge that moves its item and released right after it
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      addr <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= w;
      S_AXI_WVALID <= w;
      S_AXI_BREADY <= w;
      S_AXI_ARVALID <= !w;
      S_AXI_RREADY <= !w;
      h = {w, w, w, !w, !w};
      for (i = 0; h != 5'h00 && i < 5000; i++) begin
         @(posedge CLK);
         if (h[4] && S_AXI_AWREADY) h[4] = 1'b0;
         if (h[3] && S_AXI_WREADY) h[3] = 1'b0;
         if (h[2] && S_AXI_BVALID) begin
            h[2] = 1'b0;
            rsp = S_AXI_BRESP;
         end
         if (h[1] && S_AXI_ARREADY) h[1] = 1'b0;
         if (h[0] && S_AXI_RVALID) begin
            h[0] = 1'b0;
            rsp = S_AXI_RRESP;
            q = S_AXI_RDATA;
         end
         {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= h;
      end
      if (i == 5000) bad_count++;
      if (i == 5000) wrap_up;
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (6) @(posedge CLK);
      RESET_N <= 1'h1;
      bus(1'h0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h800);
      bus(1'h0, 8'h30, 32'h0);
      chk("resp", {30'h0, rsp}, 32'h2);
      foreach (codes[c]) begin
         bus(1'h1, 8'h04, {24'h0, codes[c]});
         bus(1'h1, 8'h04, {24'h0, codes[c]} + 32'h7);
         bus(1'h0, 8'h04, 32'h0);
         chk("rate", q, {24'h0, codes[c]});
      end
      bus(1'h1, 8'h1c, 32'h5);
      bus(1'h0, 8'h14, 32'h0);
      chk("txfree", q, 32'h5);
      bus(1'h1, 8'h1c, 32'h0);
      bus(1'h0, 8'h14, 32'h0);
      chk("txone", q, 32'h1);
      bus(1'h1, 8'h18, 32'h5);
      bus(1'h0, 8'h10, 32'h0);
      chk("rxcount", q, 32'h0);
      bus(1'h1, 8'h18, 32'h0);
      bus(1'h1, 8'h24, 32'h1);
      for (k = 0; k < 8; k++) begin
         {lsb, cpol, cpha} = k[2:0];
         len = (k == 0) ? 5'h02 : (k == 7) ? 5'h10 : 5'h02 + 5'($unsigned($random(seed)) % 15);
         t = $random(seed);
         ftx = 16'($random(seed));
         bus(1'h1, 8'h04, {24'h0, codes[$unsigned($random(seed)) % 4]});
         bus(1'h1, 8'h00, {19'h0, len, 4'h0, lsb, cpol, cpha, 1'h1});
         bus(1'h1, 8'h08, t);
         q = 32'h0;
         for (j = 0; k[0] && q == 32'h0 && j < 400; j++) bus(1'h0, 8'h10, 32'h0);
         if (k[0]) chk("rxready", q, 32'h1);
         bus(1'h0, 8'h0c, 32'h0);
         chk("mrx", q, {16'h0, ftx} & msk(len));
         chk("farrx", {16'h0, frx}, t & msk(len));
         if (k == 0) begin
            @(negedge CLK);
            chk("irqon", {31'h0, IRQ}, 32'h1);
            bus(1'h0, 8'h20, 32'h0);
            chk("istat", q & 32'h1, 32'h1);
            @(negedge CLK);
            chk("irqoff", {31'h0, IRQ}, 32'h0);
         end
      end
      bus(1'h1, 8'h24, 32'h0);
      bus(1'h1, 8'h00, 32'h800);
      t = $random(seed);
      u = $random(seed) & 32'hff;
      bus(1'h1, 8'h08, t);
      SS_N_IN <= 1'h0;
      repeat (8) @(posedge CLK);
      for (j = 7; j >= 0; j--) begin
         MOSI_IN <= u[j];
         repeat (3) @(posedge CLK);
         @(negedge CLK);
         q[j] = MISO_OUT;
         if (j == 4) chk("misooe", {31'h0, MISO_OE}, 32'h1);
         @(posedge CLK);
         SCLK_IN <= 1'h1;
         repeat (4) @(posedge CLK);
         SCLK_IN <= 1'h0;
      end
      repeat (8) @(posedge CLK);
      SS_N_IN <= 1'h1;
      MOSI_IN <= ~u[0];
      chk("sout", {24'h0, q[7:0]}, t & 32'hff);
      bus(1'h0, 8'h0c, 32'h0);
      chk("sin", q, u);
      chk("irqmask", {31'h0, IRQ}, 32'h0);
      wrap_up;
   end
endmodule // tb_top
